// ---- core/aps_pkg.sv ----
// Package of constants and types for the converter power-save control
package aps_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS      = 8;
  localparam int unsigned CONV_TIME_NS       = 1100;
  localparam int unsigned CONV_CYCLES        = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned ACQ_NORMAL_NS      = 280;
  localparam int unsigned ACQ_NORMAL_CYCLES  =
    (ACQ_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FULL_RESUME_MS     = 25;
  localparam int unsigned FULL_RESUME_CYCLES = FULL_RESUME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned REF_SETTLE_MS      = 4;
  localparam int unsigned REF_SETTLE_CYCLES  = REF_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned TRIM_CONVERSIONS   = 2;
  localparam int unsigned RESULT_W           = 18;
  localparam logic [17:0] RESULT_RESET       = 18'h00000;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [2:0] {
    APS_SHUTDOWN,
    APS_WAIT,
    APS_NAP,
    APS_CONVERT
  } aps_state_t;

  typedef struct packed {
    logic              valid;
    logic              accurate;
    logic [RESULT_W-1:0] data;
  } aps_result_t;

endpackage : aps_pkg

// ---- core/aps_ctrl.sv ----
// Power-save and result-update control of the converter
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Held result replaced at BUSY fall
// - Shutdown high powers down, low resumes
// - First two results after resume invalid
// - Conversion end with start low naps
// - Post-nap sampling at least extended acquisition
// - No new start at end waits
// - Readout independent, no sample latency
module aps_ctrl
  import aps_pkg::*;
#(
  parameter int unsigned FULL_RESUME = FULL_RESUME_CYCLES,
  parameter int unsigned REF_SETTLE  = REF_SETTLE_CYCLES
)
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                full_shutdown_input,
  input  wire logic                qualified_convert_start,
  input  wire logic                frame_sync_input,
  input  wire logic                chip_select_n,
  input  wire logic [RESULT_W-1:0] sample_code,
  output logic                     busy,
  output logic                     napping,
  output logic                     powered_down,
  output aps_result_t              held_result,
  output aps_result_t              read_result
);

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic [1:0] pd_sync_q, pd_sync_d;
  logic [1:0] cs_sync_q, cs_sync_d;
  logic [1:0] fs_sync_q, fs_sync_d;
  logic [1:0] cv_sync_q, cv_sync_d;
  logic       cv_prev_q, cv_prev_d;
  logic       cs_prev_q, cs_prev_d;
  logic       fs_prev_q, fs_prev_d;
  logic       pd_s, cv_s, cv_fall;

  always_comb
  begin
    pd_sync_d = {pd_sync_q[0], full_shutdown_input};
    cs_sync_d = {cs_sync_q[0], chip_select_n};
    fs_sync_d = {fs_sync_q[0], frame_sync_input};
    cv_sync_d = {cv_sync_q[0], qualified_convert_start};
    cv_prev_d = cv_sync_q[1];
    cs_prev_d = cs_sync_q[1];
    fs_prev_d = fs_sync_q[1];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pd_sync_q <= 2'h3;
      cs_sync_q <= 2'h3;
      fs_sync_q <= 2'h0;
      cv_sync_q <= 2'h0;
      cv_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      fs_prev_q <= 1'b0;
    end
    else
    begin
      pd_sync_q <= pd_sync_d;
      cs_sync_q <= cs_sync_d;
      fs_sync_q <= fs_sync_d;
      cv_sync_q <= cv_sync_d;
      cv_prev_q <= cv_prev_d;
      cs_prev_q <= cs_prev_d;
      fs_prev_q <= fs_prev_d;
    end
  end

  assign pd_s    = pd_sync_q[1];
  assign cv_s    = cv_sync_q[1];
  assign cv_fall = cv_prev_q & ~cv_s;

  // ****************************************************
  // Conversion and power state
  // ****************************************************
  aps_state_t  state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] acq_q, acq_d;
  logic [31:0] acq_need_q, acq_need_d;
  logic [1:0]  trim_q, trim_d;
  logic [31:0] settle_q, settle_d;
  logic        settling_q, settling_d;
  aps_result_t held_q, held_d;
  aps_result_t read_q, read_d;
  logic        frame_start;
  logic        eoc;

  assign eoc         = (state_q == APS_CONVERT) && (cnt_q == 32'h00000001);
  // Frame start on fall of chip select or rise of frame sync
  // Edges taken from the second stage only
  assign frame_start = (cs_prev_q & ~cs_sync_q[1]) | (~fs_prev_q & fs_sync_q[1]);

  always_comb
  begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    acq_d      = acq_q;
    acq_need_d = acq_need_q;
    trim_d     = trim_q;
    settle_d   = settle_q;
    settling_d = settling_q;
    held_d     = held_q;
    read_d     = read_q;
    if (state_q != APS_CONVERT && acq_q != 32'hFFFFFFFF)
      acq_d = acq_q + 32'h00000001;
    if (settling_q && settle_q != 32'h00000000)
      settle_d = settle_q - 32'h00000001;
    if (pd_s)
    begin
      // Starts ignored, BUSY low while shut down
      state_d    = APS_SHUTDOWN;
      trim_d     = 2'(TRIM_CONVERSIONS);
      settling_d = 1'b0;
      cnt_d      = 32'h00000000;
    end
    else
    begin
      unique case (state_q)
        APS_SHUTDOWN:
        begin
          // Resume: internal settle before first accurate result
          state_d    = APS_NAP;
          acq_d      = 32'h00000000;
          acq_need_d = ACQ_NORMAL_CYCLES + FULL_RESUME;
        end
        APS_WAIT, APS_NAP:
        begin
          if (cv_fall && acq_q >= acq_need_q)
          begin
            state_d = APS_CONVERT;
            cnt_d   = CONV_CYCLES;
          end
        end
        APS_CONVERT:
        begin
          if (cv_fall)
          begin
            // Abort: fresh start lands in wait
            state_d    = APS_WAIT;
            acq_d      = 32'h00000000;
            acq_need_d = ACQ_NORMAL_CYCLES;
          end
          else if (eoc)
          begin
            held_d.data     = sample_code;
            held_d.valid    = (trim_q == 2'h0);
            held_d.accurate = (trim_q == 2'h0) && settling_q && (settle_q == 32'h00000000);
            if (trim_q != 2'h0)
            begin
              trim_d = trim_q - 2'h1;
              if (trim_q == 2'h1)
              begin
                settling_d = 1'b1;
                settle_d   = REF_SETTLE;
              end
            end
            acq_d = 32'h00000000;
            if (!cv_s)
            begin
              state_d    = APS_NAP;
              acq_need_d = ACQ_NORMAL_CYCLES + FULL_RESUME;
            end
            else
            begin
              state_d    = APS_WAIT;
              acq_need_d = ACQ_NORMAL_CYCLES;
            end
          end
          else
            cnt_d = cnt_q - 32'h00000001;
        end
        default:
          state_d = APS_SHUTDOWN;
      endcase
    end
    // Readout latches the held result at frame start only
    if (frame_start)
      read_d = held_q;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q    <= APS_SHUTDOWN;
      cnt_q      <= 32'h00000000;
      acq_q      <= 32'h00000000;
      acq_need_q <= 32'h00000000;
      trim_q     <= 2'(TRIM_CONVERSIONS);
      settle_q   <= 32'h00000000;
      settling_q <= 1'b0;
      held_q     <= '{valid: 1'b0, accurate: 1'b0, data: RESULT_RESET};
      read_q     <= '{valid: 1'b0, accurate: 1'b0, data: RESULT_RESET};
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      acq_q      <= acq_d;
      acq_need_q <= acq_need_d;
      trim_q     <= trim_d;
      settle_q   <= settle_d;
      settling_q <= settling_d;
      held_q     <= held_d;
      read_q     <= read_d;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign busy         = (state_q == APS_CONVERT);
  assign napping      = (state_q == APS_NAP);
  assign powered_down = (state_q == APS_SHUTDOWN);
  assign held_result  = held_q;
  assign read_result  = read_q;

endmodule : aps_ctrl

`default_nettype wire

// ---- testbench/aps_ctrl_assertions.sv ----
// Checker of the power-save control
`timescale 1ns/1ps
`default_nettype none
module aps_ctrl_chk
  import aps_pkg::*;
(
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                full_shutdown_input,
  input wire logic                qualified_convert_start,
  input wire logic                frame_sync_input,
  input wire logic                chip_select_n,
  input wire logic [RESULT_W-1:0] sample_code,
  input wire logic                busy,
  input wire logic                napping,
  input wire logic                powered_down,
  input wire aps_result_t         held_result,
  input wire aps_result_t         read_result
);
  logic [1:0] res_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Completed results since resume; an aborted conversion is not counted
  always_ff @(posedge clk)
  begin
    if (sys_rst || powered_down)
      res_q <= 2'h0;
    else if ($fell(busy) && res_q != 2'h3
             && !($past(qualified_convert_start, 4) && !$past(qualified_convert_start, 3)))
      res_q <= res_q + 2'h1;
  end
  a_held_on_fall: assert property (
    !powered_down && $changed(held_result) |-> $fell(busy)) else $error("held moved");
  a_held_new_code: assert property (
    $fell(busy) && !$stable(held_result) |-> held_result.data == $past(sample_code))
    else $error("held code");
  a_shut_enter: assert property (
    full_shutdown_input [*5] |-> powered_down) else $error("no shutdown");
  a_shut_quiet: assert property (
    full_shutdown_input [*4] |-> !busy) else $error("active in shutdown");
  a_resume_nap: assert property (
    $fell(powered_down) |-> napping) else $error("resume not nap");
  a_nap_entry: assert property (
    (!qualified_convert_start && !full_shutdown_input) [*6] ##0 $fell(busy) |-> napping)
    else $error("no nap");
  a_wait_entry: assert property (
    qualified_convert_start [*6] ##0 $fell(busy) |-> !napping) else $error("no wait");
  a_trim_invalid: assert property (
    $fell(busy) && !powered_down
    && !($past(qualified_convert_start, 4) && !$past(qualified_convert_start, 3))
    |-> held_result.valid == (res_q >= 2'h2)) else $error("trim result valid");
  a_read_copy: assert property (
    !powered_down && $changed(read_result) |-> read_result == $past(held_result))
    else $error("read copy");
  cover property ($fell(busy) && napping);
  cover property ($fell(powered_down));
  cover property ($changed(read_result));
endmodule : aps_ctrl_chk
bind aps_ctrl aps_ctrl_chk u_chk (
  .clk                     (clk),
  .sys_rst                 (sys_rst),
  .full_shutdown_input     (full_shutdown_input),
  .qualified_convert_start (qualified_convert_start),
  .frame_sync_input        (frame_sync_input),
  .chip_select_n           (chip_select_n),
  .sample_code             (sample_code),
  .busy                    (busy),
  .napping                 (napping),
  .powered_down            (powered_down),
  .held_result             (held_result),
  .read_result             (read_result)
);
`default_nettype wire

// ---- testbench/aps_host.sv ----
// Host model driving conversion starts and read frames
`timescale 1ns/1ps
`default_nettype none
module aps_host
(
  input  wire logic clk,
  output logic      start,
  output logic      cs_n,
  output logic      fs
);
  initial
  begin
    start = 1'h1;
    cs_n  = 1'h1;
    fs    = 1'h0;
  end
  // Acquire, start, hold low to nap
  task automatic conv(input int acq, input logic nap);
    start <= 1'h1;
    repeat (acq) @(posedge clk);
    start <= 1'h0;
    repeat (8) @(posedge clk);
    start <= ~nap;
    repeat (142) @(posedge clk);
  endtask : conv
  // Frame kept clear of busy fall
  task automatic rd(input logic use_fs);
    if (use_fs) fs <= 1'h1;
    else cs_n <= 1'h0;
    repeat (6) @(posedge clk);
    fs   <= 1'h0;
    cs_n <= 1'h1;
    repeat (2) @(posedge clk);
  endtask : rd
  // Second start while busy aborts the conversion
  task automatic abort_conv();
    start <= 1'h1;
    repeat (90) @(posedge clk);
    start <= 1'h0;
    repeat (8) @(posedge clk);
    start <= 1'h1;
    repeat (20) @(posedge clk);
    start <= 1'h0;
    repeat (8) @(posedge clk);
    start <= 1'h1;
    repeat (20) @(posedge clk);
  endtask : abort_conv
endmodule : aps_host
`default_nettype wire

// ---- testbench/aps_ctrl_test.sv ----
// Self-checking bench of the power-save control
`timescale 1ns/1ps
`default_nettype none
module aps_ctrl_test
  import aps_pkg::*;
;
  logic                clk = 1'h0, sys_rst = 1'h1, pd = 1'h0;
  logic                start, cs_n, fs, busy, napping, powered_down;
  logic [RESULT_W-1:0] code = '0;
  aps_result_t         held, rd_res;
  int                  error_cnt = 0, checks = 0, n, seed = 32'hACD4BA03;
  always #4 clk = ~clk;
  aps_host u_h (.clk(clk), .start(start), .cs_n(cs_n), .fs(fs));
  aps_ctrl #(.FULL_RESUME(50), .REF_SETTLE(20)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .full_shutdown_input(pd), .qualified_convert_start(start), .frame_sync_input(fs),
    .chip_select_n(cs_n), .sample_code(code), .busy(busy), .napping(napping),
    .powered_down(powered_down), .held_result(held), .read_result(rd_res));
  function automatic aps_result_t exp_res(input int k, input logic [RESULT_W-1:0] c);
    return '{k > 2, k > 2, c};
  endfunction : exp_res
  task automatic chk(input string s, input logic [19:0] g, input logic [19:0] e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic end_sim;
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    for (int r = 0; r < 2; r++)
    begin
      n = 0;
      for (int i = 0; i < 6; i++)
      begin
        code <= RESULT_W'($random(seed));
        u_h.conv(i[0] ? 40 : 90, i[0]);
        n++;
        chk("held", held, exp_res(n, code));
        chk("nap", napping, i[0]);
        u_h.rd(i[1]);
        chk("read", rd_res, exp_res(n, code));
      end
      u_h.conv(40, 1'h1);
      chk("refused", held, exp_res(n, code));
      u_h.abort_conv();
      chk("abort", held, exp_res(n, code));
      chk("abort_st", {busy, napping}, 2'h0);
      pd <= 1'h1;
      u_h.conv(90, 1'h0);
      chk("down", {busy, powered_down}, 2'h1);
      pd <= 1'h0;
      repeat (6) @(posedge clk);
      chk("up", powered_down, 1'h0);
    end
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule : aps_ctrl_test
`default_nettype wire
